// ==== design/switch_node_config_regs.sv ====
// Configuration register bank of a packet-switch node
//
// Behaviour
// - Top bit of switch config set refuses every further register write.
// - Bit 8 of switch config set blocks PLL settings register updates.
// - Bit 0 of switch config selects one-byte headers; resets to zero.
// - Node identity holds writable 16-bit id in low half, resets zero.
// - Destination compared to own identity from most significant bit down.
// - Any accepted PLL settings write resets the attached processing tile.
// - PLL fields: output divider 25:23, multiplier 20:8, input divider 6:0.
// - At reset PLL fields load values chosen by the two boot mode pins.
// - Switch clock is PLL clock divided by switch divider plus one.
// - Reference clock is PLL clock divided by reference divider plus one.
// - Mismatching packet goes in direction of most significant differing bit.
// - Low table holds 4-bit directions for identity bits 0 to 7.
// - High table holds 4-bit directions for identity bits 8 to 15.
// - Debug config bit 1 lets the debug request pin raise a trap.
// - Debug config bit 0 pulls debug wire low on entering debug mode.
// - Debug source bit 4 marks the pin as latest debug cause.
// - Debug source bit 0 marks the tile as latest debug cause.
// - Registers are serviced by number through configuration accesses.
`timescale 1ns/10ps
`include "switch_node_map.svh"
module switch_node_config_regs
   import switch_node_pkg::*;
#(
   parameter int ID_WIDTH  = 16,
   parameter int DIR_WIDTH = 4
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   input  wire cfg_request_t         cfg_req,
   output cfg_answer_t               cfg_ans,
   input  wire logic                 boot_mode_pin_low,
   input  wire logic                 boot_mode_pin_high,
   input  wire logic                 pll_clk,
   output logic                      switch_clk_en,
   output logic                      reference_clk_en,
   input  wire logic                 route_valid,
   input  wire logic [ID_WIDTH-1:0]  route_dest,
   output logic                      route_match,
   output logic [DIR_WIDTH-1:0]      route_direction,
   output logic                      short_header_mode,
   output logic [2:0]                pll_output_divider,
   output logic [12:0]               pll_feedback_ratio,
   output logic [6:0]                pll_input_divider,
   output logic                      tile_reset,
   input  wire logic                 debug_req_in,
   output logic                      debug_req_out,
   output logic                      debug_req_oe,
   input  wire logic                 debug_mode_enter,
   input  wire logic                 tile_debug_event,
   output logic                      debug_call_trap
);
   // ==========================================================
   // Register state
   logic [31:0]          switch_lock_and_header_cfg;
   logic [ID_WIDTH-1:0]  node_identity;
   logic [31:0]          pll_ratio_settings;
   logic [15:0]          switch_clock_divider;
   logic [15:0]          reference_clock_divider;
   logic [31:0]          route_directions_low;
   logic [31:0]          route_directions_high;
   logic [31:0]          debug_pin_config;
   logic [31:0]          debug_event_origin;
   boot_state_t          boot_state;
   logic                 debug_req_prev;
   logic                 write_locked;
   logic                 pll_locked;
   logic                 wr;
   logic                 wr_ok;
   logic                 pll_wr_ok;
   logic                 pin_event;
   logic [31:0]          read_data;

   // ==========================================================
   // Write qualification
   assign wr           = cfg_req.valid & cfg_req.write;
   assign write_locked = switch_lock_and_header_cfg[`BIT_WRITE_LOCK_ALL];
   assign pll_locked   = switch_lock_and_header_cfg[`BIT_WRITE_LOCK_PLL];
   // Whole-bank lock wins over everything, including its own release
   assign wr_ok        = wr & ~write_locked;
   assign pll_wr_ok    = wr_ok & ~pll_locked
                         & (cfg_req.number == `REG_PLL_RATIO_SETTINGS);

   // Lock and header register; bit 31 guards itself, so it holds till reset
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         switch_lock_and_header_cfg <= 32'h0000_0000;
      end else if (wr_ok &&
                   cfg_req.number == `REG_SWITCH_LOCK_AND_HEADER_CFG) begin
         switch_lock_and_header_cfg <= cfg_req.data & `CFG_WRITE_MASK;
      end
   end
   assign short_header_mode = switch_lock_and_header_cfg[`BIT_SHORT_HEADER];

   // Node identity and clock dividers
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         node_identity           <= '0;
         switch_clock_divider    <= `RST_SWITCH_CLOCK_DIVIDER;
         reference_clock_divider <= `RST_REFERENCE_CLOCK_DIVIDER;
      end else if (wr_ok) begin
         if (cfg_req.number == `REG_NODE_IDENTITY) begin
            node_identity <= cfg_req.data[ID_WIDTH-1:0];
         end else if (cfg_req.number == `REG_SWITCH_CLOCK_DIVIDER) begin
            switch_clock_divider <= cfg_req.data[15:0];
         end else if (cfg_req.number == `REG_REFERENCE_CLOCK_DIVIDER) begin
            reference_clock_divider <= cfg_req.data[15:0];
         end
      end
   end

   // Direction tables
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         route_directions_low  <= 32'h0000_0000;
         route_directions_high <= 32'h0000_0000;
      end else if (wr_ok) begin
         if (cfg_req.number == `REG_ROUTE_DIRECTIONS_LOW) begin
            route_directions_low <= cfg_req.data;
         end else if (cfg_req.number == `REG_ROUTE_DIRECTIONS_HIGH) begin
            route_directions_high <= cfg_req.data;
         end
      end
   end

   // ==========================================================
   // PLL settings: boot value captured one cycle after reset release,
   // as well as during reset itself, both times from the boot mode pins
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         boot_state <= BOOT_CAPTURE;
      end else begin
         case (boot_state)
            BOOT_CAPTURE: boot_state <= RUNNING;
            default:      boot_state <= RUNNING;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b || boot_state == BOOT_CAPTURE) begin
         case ({boot_mode_pin_high, boot_mode_pin_low})
            2'b00:   pll_ratio_settings <= `PLL_BOOT_BOOT_MODE_PIN_LOW;
            2'b01:   pll_ratio_settings <= `PLL_BOOT_BOOT_MODE_PIN_HIGH;
            2'b10:   pll_ratio_settings <= `PLL_BOOT_MODE2;
            default: pll_ratio_settings <= `PLL_BOOT_MODE3;
         endcase
      end else if (pll_wr_ok) begin
         pll_ratio_settings <= cfg_req.data & `PLL_WRITE_MASK;
      end
   end
   assign pll_output_divider = pll_ratio_settings[`PLL_OD_MSB:`PLL_OD_LSB];
   assign pll_feedback_ratio = pll_ratio_settings[`PLL_F_MSB:`PLL_F_LSB];
   assign pll_input_divider  = pll_ratio_settings[`PLL_R_MSB:`PLL_R_LSB];

   // Tile reset pulse only on an accepted PLL write
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tile_reset <= 1'b0;
      end else begin
         tile_reset <= pll_wr_ok;
      end
   end

   // ==========================================================
   // Clock enables derived from the PLL clock; counters run on core_clk
   // with pll_clk treated as a synchronous tick input
   logic [15:0] sw_count;
   logic [15:0] ref_count;
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sw_count      <= 16'h0000;
         switch_clk_en <= 1'b0;
      end else if (pll_clk) begin
         switch_clk_en <= (sw_count >= switch_clock_divider);
         sw_count <= (sw_count >= switch_clock_divider) ? 16'h0000
                     : sw_count + 16'h0001;
      end else begin
         switch_clk_en <= 1'b0;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ref_count        <= 16'h0000;
         reference_clk_en <= 1'b0;
      end else if (pll_clk) begin
         reference_clk_en <= (ref_count >= reference_clock_divider);
         ref_count <= (ref_count >= reference_clock_divider) ? 16'h0000
                      : ref_count + 16'h0001;
      end else begin
         reference_clk_en <= 1'b0;
      end
   end

   // ==========================================================
   // Routing: most significant mismatching identity bit picks direction
   logic [ID_WIDTH-1:0]  diff;
   logic [2*ID_WIDTH*DIR_WIDTH/2-1:0] dir_table;
   logic [DIR_WIDTH-1:0] next_direction;
   assign diff      = route_dest ^ node_identity;
   assign dir_table = {route_directions_high, route_directions_low};
   always_comb begin
      next_direction = '0;
      for (int i = 0; i < ID_WIDTH; i++) begin
         if (diff[i]) begin
            next_direction = dir_table[i*DIR_WIDTH +: DIR_WIDTH];
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         route_match     <= 1'b0;
         route_direction <= '0;
      end else if (route_valid) begin
         route_match     <= (diff == '0);
         route_direction <= next_direction;
      end
   end

   // ==========================================================
   // Debug pin and source
   assign pin_event = debug_req_in & ~debug_req_prev;
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         debug_pin_config   <= 32'h0000_0000;
         debug_event_origin <= 32'h0000_0000;
         debug_req_prev     <= 1'b1; // Idle level, no false edge
         debug_call_trap    <= 1'b0;
         debug_req_oe       <= 1'b0;
      end else begin
         debug_req_prev  <= debug_req_in;
         debug_call_trap <= pin_event
                            & debug_pin_config[`BIT_DEBUG_TRAP_ENABLE];
         if (debug_mode_enter && debug_pin_config[`BIT_DEBUG_PULL_ENABLE]) begin
            debug_req_oe <= 1'b1;
         end else if (!debug_mode_enter) begin
            debug_req_oe <= 1'b0;
         end
         if (wr_ok && cfg_req.number == `REG_DEBUG_PIN_CONFIG) begin
            debug_pin_config <= cfg_req.data & `DEBUG_CFG_MASK;
         end
         // Hardware events win over a software write in the same cycle
         if ((pin_event && debug_pin_config[`BIT_DEBUG_TRAP_ENABLE])
             || tile_debug_event) begin
            debug_event_origin <= {27'h0, tile_debug_event ? 1'b0 : 1'b1,
                                   3'h0, tile_debug_event};
         end else if (wr_ok && cfg_req.number == `REG_DEBUG_EVENT_ORIGIN) begin
            debug_event_origin <= cfg_req.data & `ORIGIN_MASK;
         end
      end
   end
   assign debug_req_out = 1'b0;

   // ==========================================================
   // Read mux and answer, one cycle after the request
   always_comb begin
      read_data = 32'h0000_0000;
      if (cfg_req.number == `REG_SWITCH_LOCK_AND_HEADER_CFG) begin
         read_data = switch_lock_and_header_cfg;
      end else if (cfg_req.number == `REG_NODE_IDENTITY) begin
         read_data = {16'h0000, node_identity};
      end else if (cfg_req.number == `REG_PLL_RATIO_SETTINGS) begin
         read_data = pll_ratio_settings;
      end else if (cfg_req.number == `REG_SWITCH_CLOCK_DIVIDER) begin
         read_data = {16'h0000, switch_clock_divider};
      end else if (cfg_req.number == `REG_REFERENCE_CLOCK_DIVIDER) begin
         read_data = {16'h0000, reference_clock_divider};
      end else if (cfg_req.number == `REG_ROUTE_DIRECTIONS_LOW) begin
         read_data = route_directions_low;
      end else if (cfg_req.number == `REG_ROUTE_DIRECTIONS_HIGH) begin
         read_data = route_directions_high;
      end else if (cfg_req.number == `REG_DEBUG_PIN_CONFIG) begin
         read_data = debug_pin_config;
      end else if (cfg_req.number == `REG_DEBUG_EVENT_ORIGIN) begin
         read_data = debug_event_origin;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cfg_ans <= '0;
      end else begin
         cfg_ans.valid   <= cfg_req.valid;
         cfg_ans.refused <= wr & (write_locked | (pll_locked &
            (cfg_req.number == `REG_PLL_RATIO_SETTINGS)));
         cfg_ans.data    <= cfg_req.write ? 32'h0000_0000 : read_data;
      end
   end

   // ==========================================================
   // Checks
   property p_lock_all;
      @(posedge core_clk) disable iff (!rst_b)
      (wr && write_locked) |=> $stable(node_identity)
                               && $stable(route_directions_low);
   endproperty
   a_lock_all: assert property (p_lock_all) else $error("locked write");

   property p_lock_pll;
      @(posedge core_clk) disable iff (!rst_b)
      (boot_state == RUNNING && pll_locked) |=> $stable(pll_ratio_settings);
   endproperty
   a_lock_pll: assert property (p_lock_pll) else $error("pll changed");

   property p_tile_reset;
      @(posedge core_clk) disable iff (!rst_b)
      pll_wr_ok |=> tile_reset;
   endproperty
   a_tile_reset: assert property (p_tile_reset) else $error("no reset");

   property p_no_side_effect;
      @(posedge core_clk) disable iff (!rst_b)
      !pll_wr_ok |=> !tile_reset;
   endproperty
   a_no_side_effect: assert property (p_no_side_effect)
      else $error("stray reset");

   property p_header;
      @(posedge core_clk) disable iff (!rst_b)
      !(wr_ok && cfg_req.number == `REG_SWITCH_LOCK_AND_HEADER_CFG)
         |=> $stable(short_header_mode);
   endproperty
   a_header: assert property (p_header) else $error("header mode");

   property p_match;
      @(posedge core_clk) disable iff (!rst_b)
      (route_valid && route_dest == node_identity) |=> route_match;
   endproperty
   a_match: assert property (p_match) else $error("match lost");

   property p_trap;
      @(posedge core_clk) disable iff (!rst_b)
      (pin_event && !debug_pin_config[1]) |=> !debug_call_trap;
   endproperty
   a_trap: assert property (p_trap) else $error("trap not gated");

   property p_reserved;
      @(posedge core_clk) disable iff (!rst_b)
      debug_event_origin[3:1] == 3'h0 && debug_pin_config[31:2] == '0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved set");
endmodule

// ==== inc/switch_node_map.svh ====
// Register numbers, field positions, reset values of the switch node bank
`ifndef SWITCH_NODE_MAP_SVH
`define SWITCH_NODE_MAP_SVH
`define REG_SWITCH_LOCK_AND_HEADER_CFG 8'h04
`define REG_NODE_IDENTITY              8'h05
`define REG_PLL_RATIO_SETTINGS         8'h06
`define REG_SWITCH_CLOCK_DIVIDER       8'h07
`define REG_REFERENCE_CLOCK_DIVIDER    8'h08
`define REG_ROUTE_DIRECTIONS_LOW       8'h0C
`define REG_ROUTE_DIRECTIONS_HIGH      8'h0D
`define REG_DEBUG_PIN_CONFIG           8'h10
`define REG_DEBUG_EVENT_ORIGIN         8'h1F
`define BIT_WRITE_LOCK_ALL             31
`define BIT_WRITE_LOCK_PLL             8
`define BIT_SHORT_HEADER               0
`define BIT_DEBUG_TRAP_ENABLE          1
`define BIT_DEBUG_PULL_ENABLE          0
`define BIT_ORIGIN_PIN                 4
`define BIT_ORIGIN_TILE                0
`define PLL_OD_MSB                     25
`define PLL_OD_LSB                     23
`define PLL_F_MSB                      20
`define PLL_F_LSB                      8
`define PLL_R_MSB                      6
`define PLL_R_LSB                      0
`define CFG_WRITE_MASK                 32'h8000_0101
`define PLL_WRITE_MASK                 32'h03FF_FF7F
`define HALF_WRITE_MASK                32'h0000_FFFF
`define DEBUG_CFG_MASK                 32'h0000_0003
`define ORIGIN_MASK                    32'h0000_0011
`define RST_SWITCH_CLOCK_DIVIDER       16'h0000
`define RST_REFERENCE_CLOCK_DIVIDER    16'h0003
// Boot PLL words per boot mode pin pair (high,low)
`define PLL_BOOT_BOOT_MODE_PIN_LOW                 32'h0080_0000
`define PLL_BOOT_BOOT_MODE_PIN_HIGH                 32'h0080_1300
`define PLL_BOOT_MODE2                 32'h0080_3100
`define PLL_BOOT_MODE3                 32'h0080_6300
`endif

// ==== inc/switch_node_pkg.sv ====
// Types shared by the switch node configuration bank
package switch_node_pkg;
   // One configuration access from the switch
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  number;
      logic [31:0] data;
   } cfg_request_t;
   // Answer to a configuration access
   typedef struct packed {
      logic        valid;
      logic        refused;
      logic [31:0] data;
   } cfg_answer_t;
   typedef enum logic [1:0] {
      BOOT_CAPTURE,
      RUNNING
   } boot_state_t;
endpackage

// ==== verification/cfg_master_model.sv ====
// Configuration master model that reaches the node bank over the switch
`timescale 1ns/10ps
module cfg_master_model
   import switch_node_pkg::*;
(
   input  wire logic        core_clk,
   input  wire cfg_answer_t cfg_ans,
   output cfg_request_t     cfg_req
);
   // ==========================================================
   // Bus state
   int timeouts;

   initial begin
      cfg_req = '0;
      cfg_req.data = 32'h5A5A_5A5A;
      timeouts = 0;
   end

   // One whole-word access by register number; header mode is written the
   // same way on every node, so the model never special-cases it
   task automatic access(input logic wr, input logic [7:0] num,
      input logic [31:0] wdata, output logic refused,
      output logic [31:0] rdata);
      int n;
      @(negedge core_clk);
      cfg_req.valid = 1'b1;
      cfg_req.write = wr;
      cfg_req.number = num;
      cfg_req.data = wdata;
      @(negedge core_clk);
      cfg_req.valid = 1'b0;
      // Released data no longer shows the last word
      cfg_req.data = ~wdata;
      n = 0;
      while (cfg_ans.valid !== 1'b1 && n < 4) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 4) begin
         timeouts++;
      end
      refused = cfg_ans.refused;
      rdata = cfg_ans.data;
   endtask
endmodule

// ==== verification/switch_node_config_regs_tb.sv ====
// Self-checking bench of the switch node configuration bank
`timescale 1ns/10ps
`include "switch_node_map.svh"
module switch_node_config_regs_tb
   import switch_node_pkg::*;
;
   // ==========================================================
   // Signals
   logic         core_clk, rst_b, strap_lo, strap_hi, pll_clk;
   logic         route_valid, route_match, short_header_mode;
   logic [15:0]  route_dest;
   logic [3:0]   route_direction;
   logic [2:0]   pll_od;
   logic [12:0]  pll_f;
   logic [6:0]   pll_r;
   logic         sw_en, ref_en, tile_reset, debug_call_trap;
   logic         debug_req_out, debug_req_oe, debug_pin;
   logic         debug_mode_enter, tile_debug_event;
   wire          debug_req_in;
   cfg_request_t cfg_req;
   cfg_answer_t  cfg_ans;
   int           fail_count, total_checks, cycles;
   int           resets_seen, traps_seen, sw_gap, sw_last, ref_gap, ref_last;

   // Pin has a pull-up; the node pulls it low when enabled
   assign debug_req_in = (debug_req_oe === 1'b1) ? debug_req_out : debug_pin;

   switch_node_config_regs dut (.core_clk(core_clk), .rst_b(rst_b),
      .cfg_req(cfg_req), .cfg_ans(cfg_ans), .boot_mode_pin_low(strap_lo),
      .boot_mode_pin_high(strap_hi), .pll_clk(pll_clk),
      .switch_clk_en(sw_en), .reference_clk_en(ref_en),
      .route_valid(route_valid), .route_dest(route_dest),
      .route_match(route_match), .route_direction(route_direction),
      .short_header_mode(short_header_mode), .pll_output_divider(pll_od),
      .pll_feedback_ratio(pll_f), .pll_input_divider(pll_r),
      .tile_reset(tile_reset), .debug_req_in(debug_req_in),
      .debug_req_out(debug_req_out), .debug_req_oe(debug_req_oe),
      .debug_mode_enter(debug_mode_enter),
      .tile_debug_event(tile_debug_event),
      .debug_call_trap(debug_call_trap));

   cfg_master_model master (.core_clk(core_clk), .cfg_ans(cfg_ans),
      .cfg_req(cfg_req));

   // ==========================================================
   // Clock, pulse monitors and hang guard
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles++;
      if (tile_reset === 1'b1) resets_seen++;
      if (debug_call_trap === 1'b1) traps_seen++;
      if (sw_en === 1'b1) begin
         sw_gap = cycles - sw_last;
         sw_last = cycles;
      end
      if (ref_en === 1'b1) begin
         ref_gap = cycles - ref_last;
         ref_last = cycles;
      end
      if (cycles == 5000) begin
         fail_count++;
         wrap_up();
      end
   end

   // ==========================================================
   // Compare and bus tasks
   task automatic check_word(input logic [31:0] got, exp, input string s);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task automatic check_flag(input logic got, exp, input string s);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s got %b exp %b", $time, s, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] n, input logic [31:0] d, input logic x);
      logic        r;
      logic [31:0] q;
      master.access(1'b1, n, d, r, q);
      check_flag(r, x, "refused flag");
   endtask

   task automatic rd(input logic [7:0] n, input logic [31:0] exp);
      logic        r;
      logic [31:0] q;
      master.access(1'b0, n, 32'h0000_0000, r, q);
      check_word(q, exp, "read word");
   endtask

   task automatic do_reset(input logic hi, lo);
      @(negedge core_clk);
      rst_b = 1'b0;
      strap_hi = hi;
      strap_lo = lo;
      repeat (10) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (2) @(negedge core_clk);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_boot;
      logic [31:0] boot [4];
      boot = '{`PLL_BOOT_BOOT_MODE_PIN_LOW, `PLL_BOOT_BOOT_MODE_PIN_HIGH, `PLL_BOOT_MODE2,
               `PLL_BOOT_MODE3};
      for (int m = 0; m < 4; m++) begin
         do_reset(m[1], m[0]);
         rd(`REG_PLL_RATIO_SETTINGS, boot[m]);
         check_word({9'h0, pll_od, pll_f, pll_r},
            {9'h0, boot[m][25:23], boot[m][20:8], boot[m][6:0]}, "pll");
      end
      rd(`REG_SWITCH_LOCK_AND_HEADER_CFG, 32'h0000_0000);
      check_flag(short_header_mode, 1'b0, "header");
      rd(`REG_NODE_IDENTITY, 32'h0000_0000);
      rd(`REG_SWITCH_CLOCK_DIVIDER, 32'h0000_0000);
      rd(`REG_REFERENCE_CLOCK_DIVIDER, 32'h0000_0003);
      rd(`REG_ROUTE_DIRECTIONS_LOW, 32'h0000_0000);
      rd(`REG_ROUTE_DIRECTIONS_HIGH, 32'h0000_0000);
      rd(`REG_DEBUG_PIN_CONFIG, 32'h0000_0000);
      rd(8'h02, 32'h0000_0000);
   endtask

   task automatic clk_gaps(input int s, r);
      pll_clk = 1'b1;
      repeat (24) @(negedge core_clk);
      check_word(32'(sw_gap), 32'(s), "switch gap");
      check_word(32'(ref_gap), 32'(r), "ref gap");
      pll_clk = 1'b0;
   endtask

   task automatic t_fields;
      int n;
      wr(`REG_NODE_IDENTITY, 32'hFFFF_FFFF, 1'b0);
      rd(`REG_NODE_IDENTITY, 32'h0000_FFFF);
      wr(`REG_SWITCH_CLOCK_DIVIDER, 32'hFFFF_0002, 1'b0);
      rd(`REG_SWITCH_CLOCK_DIVIDER, 32'h0000_0002);
      wr(`REG_REFERENCE_CLOCK_DIVIDER, 32'h0000_0004, 1'b0);
      wr(`REG_ROUTE_DIRECTIONS_LOW, 32'h7654_3210, 1'b0);
      rd(`REG_ROUTE_DIRECTIONS_LOW, 32'h7654_3210);
      wr(`REG_ROUTE_DIRECTIONS_HIGH, 32'hFEDC_BA98, 1'b0);
      rd(`REG_ROUTE_DIRECTIONS_HIGH, 32'hFEDC_BA98);
      wr(`REG_DEBUG_PIN_CONFIG, 32'hFFFF_FFFC, 1'b0);
      rd(`REG_DEBUG_PIN_CONFIG, 32'h0000_0000);
      wr(`REG_SWITCH_LOCK_AND_HEADER_CFG, 32'h0000_0001, 1'b0);
      check_flag(short_header_mode, 1'b1, "header");
      n = resets_seen;
      wr(`REG_PLL_RATIO_SETTINGS, 32'hFFFF_FFFF, 1'b0);
      rd(`REG_PLL_RATIO_SETTINGS, 32'h03FF_FF7F);
      check_word(32'(resets_seen - n), 32'h1, "tile reset");
      check_word({9'h0, pll_od, pll_f, pll_r}, 32'h007F_FFFF, "pll");
   endtask

   task automatic t_route;
      wr(`REG_NODE_IDENTITY, 32'h0000_A5C3, 1'b0);
      // Every lower bit also differs, so only the top difference may count
      for (int b = 0; b < 17; b++) begin
         @(negedge core_clk);
         route_valid = 1'b1;
         route_dest = (b == 16) ? 16'hA5C3 : 16'hA5C3 ^ 16'((32'h2 << b) - 1);
         @(negedge core_clk);
         route_valid = 1'b0;
         route_dest = ~route_dest;
         check_flag(route_match, b == 16, "match");
         check_word({28'h0, route_direction}, (b == 16) ? 0 : b, "dir");
      end
   endtask

   task automatic pin_pulse;
      @(negedge core_clk);
      debug_pin = 1'b0;
      repeat (2) @(negedge core_clk);
      debug_pin = 1'b1;
      repeat (4) @(negedge core_clk);
   endtask

   task automatic t_debug;
      int n;
      n = traps_seen;
      pin_pulse();
      check_word(32'(traps_seen - n), 32'h0, "trap off");
      wr(`REG_DEBUG_PIN_CONFIG, 32'h0000_0002, 1'b0);
      pin_pulse();
      check_word(32'(traps_seen - n), 32'h1, "trap on");
      rd(`REG_DEBUG_EVENT_ORIGIN, 32'h0000_0010);
      @(negedge core_clk);
      tile_debug_event = 1'b1;
      @(negedge core_clk);
      tile_debug_event = 1'b0;
      repeat (3) @(negedge core_clk);
      rd(`REG_DEBUG_EVENT_ORIGIN, 32'h0000_0001);
      debug_mode_enter = 1'b1;
      repeat (3) @(negedge core_clk);
      check_flag(debug_req_oe, 1'b0, "pull off");
      wr(`REG_DEBUG_PIN_CONFIG, 32'h0000_0003, 1'b0);
      repeat (3) @(negedge core_clk);
      check_flag(debug_req_oe, 1'b1, "pull on");
      check_flag(debug_req_in, 1'b0, "pin low");
      debug_mode_enter = 1'b0;
   endtask

   task automatic t_locks;
      int n;
      wr(`REG_SWITCH_LOCK_AND_HEADER_CFG, 32'h0000_0101, 1'b0);
      n = resets_seen;
      wr(`REG_PLL_RATIO_SETTINGS, 32'h0000_0000, 1'b1);
      rd(`REG_PLL_RATIO_SETTINGS, 32'h03FF_FF7F);
      check_word(32'(resets_seen - n), 32'h0, "no reset");
      wr(`REG_NODE_IDENTITY, 32'h0000_1234, 1'b0);
      wr(`REG_SWITCH_LOCK_AND_HEADER_CFG, 32'h8000_0101, 1'b0);
      wr(`REG_NODE_IDENTITY, 32'h0000_5678, 1'b1);
      rd(`REG_NODE_IDENTITY, 32'h0000_1234);
      wr(`REG_ROUTE_DIRECTIONS_LOW, 32'h0000_0000, 1'b1);
      rd(`REG_ROUTE_DIRECTIONS_LOW, 32'h7654_3210);
      // The whole-bank lock also guards its own register
      wr(`REG_SWITCH_LOCK_AND_HEADER_CFG, 32'h0000_0000, 1'b1);
      rd(`REG_SWITCH_LOCK_AND_HEADER_CFG, 32'h8000_0101);
      do_reset(1'b0, 1'b0);
      rd(`REG_SWITCH_LOCK_AND_HEADER_CFG, 32'h0000_0000);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {rst_b, strap_lo, strap_hi, pll_clk, route_valid} = 5'h00;
      {debug_mode_enter, tile_debug_event, debug_pin} = 3'h1;
      route_dest = 16'h0000;
      {fail_count, total_checks, cycles, resets_seen, traps_seen} = 0;
      {sw_gap, sw_last, ref_gap, ref_last} = 0;
      t_boot();
      clk_gaps(1, 4);
      t_fields();
      clk_gaps(3, 5);
      t_route();
      t_debug();
      t_locks();
      check_word(32'(master.timeouts), 32'h0, "answers");
      wrap_up();
   end
endmodule
